//--- include/pcie_link_regs_pkg.sv
/*
 * Constants and carrier types for the link capability and link control
 * register bank of an endpoint function.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package pcie_link_regs_pkg;

	// Byte offsets inside the capability structure
	localparam logic [7:0] LINK_CAP_OFFSET  = 8'h0C;
	localparam logic [7:0] LINK_CTRL_OFFSET = 8'h10;

	// Link capabilities field positions
	localparam int PORT_NUM_LSB      = 24;
	localparam int ASPM_OPT_BIT      = 22;
	localparam int BW_NOTIFY_BIT     = 21;
	localparam int LINK_ACTIVE_BIT   = 20;
	localparam int SURPRISE_DOWN_BIT = 19;
	localparam int CLK_REMOVAL_BIT   = 18;
	localparam int L1_EXIT_LSB       = 15;
	localparam int L0S_EXIT_LSB      = 12;
	localparam int ASPM_SUPPORT_LSB  = 10;
	localparam int MAX_LANES_LSB     = 4;
	localparam int SPEEDS_LSB        = 0;

	// Link control field positions
	localparam int ASPM_CTRL_LSB  = 0;
	localparam int COMPL_BND_BIT  = 3;
	localparam int COMMON_CLK_BIT = 6;
	localparam int EXT_SYNCH_BIT  = 7;
	localparam int CLK_PM_EN_BIT  = 8;
	localparam int AUTO_WIDTH_BIT = 9;

	// Reset values
	localparam logic [1:0]  ASPM_CTRL_RST  = 2'h0;
	localparam logic        CTRL_BIT_RST   = 1'b0;
	localparam logic [31:0] RDATA_RST      = 32'h0000_0000;
	localparam logic [7:0]  PORT_NUM_RST   = 8'h00;

	// Avalon-MM request from the master
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} av_req_t;

	// Link layer status seen by the bank
	typedef struct packed {
		logic link_low_power;   // Link in L1 or L2/L3 Ready
		logic clk_wake;         // Local need for the reference clock
		logic l0s_exiting;
		logic in_recovery;
		logic width_change_req;
		logic width_reduce_fix; // Change reduces width for reliability
	} link_stat_t;

	// CLKREQ# handling states
	typedef enum logic [0:0] {
		CLK_HELD     = 1'b0,
		CLK_RELEASED = 1'b1
	} clkreq_state_t;

endpackage : pcie_link_regs_pkg

//--- src/pcie_link_cap_ctrl_regs.sv
/*
 * Link capability and link control register bank with the link-side
 * steering outputs that the control bits drive.
 * Assumes an Avalon-MM master that holds its request until it sees
 * waitrequest low, and link status inputs synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module pcie_link_cap_ctrl_regs
	import pcie_link_regs_pkg::*;
#(
	parameter logic [3:0] SUPPORTED_SPEEDS   = 4'h1,
	parameter logic [5:0] MAX_LANES          = 6'h04,
	parameter logic [1:0] ASPM_SUPPORT       = 2'h3,
	parameter logic [2:0] L0S_EXIT_CODE      = 3'h1,
	parameter logic [2:0] L1_EXIT_CODE       = 3'h2,
	parameter logic       CLK_REMOVAL_OK     = 1'b1,
	parameter logic       ASPM_OPTIONALITY   = 1'b1,
	parameter logic       AUTO_WIDTH_CAPABLE = 1'b1
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// Avalon-MM slave
	input  wire av_req_t    av_req,
	output logic [31:0]     av_readdata,
	output logic            av_waitrequest,
	// Hardware init strap
	input  wire logic [7:0] port_number_strap,
	// Link layer status
	input  wire link_stat_t link_stat,
	// Link layer steering
	output logic [1:0]      aspm_control_level,
	output logic            common_clock_config,
	output logic            extended_synch,
	output logic            completion_boundary,
	output logic            autonomous_width_disable,
	output logic            tx_extra_ordered_sets,
	output logic            width_change_grant,
	// CLKREQ# open-drain pin
	output logic            clkreq_out,
	output logic            clkreq_oe_n
);

	// Whole module state
	typedef struct packed {
		logic [31:0]   rdata;
		logic          wait_req;
		logic [1:0]    aspm_ctrl;
		logic          compl_bnd;
		logic          common_clk;
		logic          ext_synch;
		logic          clk_pm_en;
		logic          auto_width_dis;
		logic [7:0]    port_num;
		logic          strap_done;
		logic          extra_os;
		logic          width_grant;
		logic          clkreq_lvl;
		clkreq_state_t clk_st;
	} state_t;

	state_t st_q;
	state_t st_d;

	logic        take;
	logic [31:0] cap_word;
	logic [31:0] ctrl_word;

	// Capability word assembled from parameters and captured port number
	always_comb begin
		cap_word = 32'h0000_0000;
		cap_word[PORT_NUM_LSB +: 8]    = st_q.port_num;
		cap_word[ASPM_OPT_BIT]         = ASPM_OPTIONALITY;
		cap_word[BW_NOTIFY_BIT]        = 1'b0;
		cap_word[LINK_ACTIVE_BIT]      = 1'b0;
		cap_word[SURPRISE_DOWN_BIT]    = 1'b0;
		cap_word[CLK_REMOVAL_BIT]      = CLK_REMOVAL_OK;
		cap_word[L1_EXIT_LSB +: 3]     = L1_EXIT_CODE;
		cap_word[L0S_EXIT_LSB +: 3]    = L0S_EXIT_CODE;
		cap_word[ASPM_SUPPORT_LSB +: 2] = ASPM_SUPPORT;
		cap_word[MAX_LANES_LSB +: 6]   = MAX_LANES;
		cap_word[SPEEDS_LSB +: 4]      = SUPPORTED_SPEEDS;
	end

	// Control word; unlisted bits stay zero
	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[ASPM_CTRL_LSB +: 2] = st_q.aspm_ctrl;
		ctrl_word[COMPL_BND_BIT]      = st_q.compl_bnd;
		ctrl_word[COMMON_CLK_BIT]     = st_q.common_clk;
		ctrl_word[EXT_SYNCH_BIT]      = st_q.ext_synch;
		ctrl_word[CLK_PM_EN_BIT]      = st_q.clk_pm_en;
		ctrl_word[AUTO_WIDTH_BIT]     = st_q.auto_width_dis;
	end

	// Request taken only while waitrequest is high, so a held request
	// is served exactly once
	assign take = (av_req.read | av_req.write) & st_q.wait_req;

	// Next state
	always_comb begin
		st_d = st_q;

		// Port number caught once, first edge after reset release
		if (!st_q.strap_done) begin
			st_d.port_num   = port_number_strap;
			st_d.strap_done = 1'b1;
		end

		// Bus answer: waitrequest low for one cycle after the take
		st_d.wait_req = 1'b1;
		if (take) begin
			st_d.wait_req = 1'b0;
			st_d.rdata    = RDATA_RST;
		end

		// Read decode; unmapped addresses read zero
		if (take && av_req.read) begin
			if (av_req.address == LINK_CAP_OFFSET) begin
				st_d.rdata = cap_word;
			end else if (av_req.address == LINK_CTRL_OFFSET) begin
				st_d.rdata = ctrl_word;
			end
		end

		// Write decode; capability and unmapped writes dropped
		if (take && av_req.write && av_req.address == LINK_CTRL_OFFSET) begin
			if (av_req.byteenable[0]) begin
				st_d.aspm_ctrl  = av_req.writedata[ASPM_CTRL_LSB +: 2];
				st_d.compl_bnd  = av_req.writedata[COMPL_BND_BIT];
				st_d.common_clk = av_req.writedata[COMMON_CLK_BIT];
				st_d.ext_synch  = av_req.writedata[EXT_SYNCH_BIT];
			end
			if (av_req.byteenable[1]) begin
				st_d.clk_pm_en = av_req.writedata[CLK_PM_EN_BIT];
				// Hardwired zero without width capability
				st_d.auto_width_dis = AUTO_WIDTH_CAPABLE &
					av_req.writedata[AUTO_WIDTH_BIT];
			end
		end

		// Extra ordered sets on L0s exit and during Recovery
		st_d.extra_os = st_q.ext_synch &
			(link_stat.l0s_exiting | link_stat.in_recovery);

		// Width changes only for reliability when disabled
		st_d.width_grant = link_stat.width_change_req &
			(!st_q.auto_width_dis | link_stat.width_reduce_fix);

		// CLKREQ#: level is always low; release is by output enable
		st_d.clkreq_lvl = 1'b0;
		case (st_q.clk_st)
			CLK_HELD: begin
				// Release only when allowed and clock removal is tolerated
				if (st_q.clk_pm_en && CLK_REMOVAL_OK &&
					link_stat.link_low_power && !link_stat.clk_wake) begin
					st_d.clk_st = CLK_RELEASED;
				end
			end
			CLK_RELEASED: begin
				// Disable pulls the pin low at once
				if (!st_q.clk_pm_en || !link_stat.link_low_power ||
					link_stat.clk_wake) begin
					st_d.clk_st = CLK_HELD;
				end
			end
			default: begin
				st_d.clk_st = CLK_HELD;
			end
		endcase
		// Writing the enable to zero forces the hold on the same edge
		if (!st_d.clk_pm_en) begin
			st_d.clk_st = CLK_HELD;
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q.rdata          <= RDATA_RST;
			st_q.wait_req       <= 1'b1;
			st_q.aspm_ctrl      <= ASPM_CTRL_RST;
			st_q.compl_bnd      <= CTRL_BIT_RST;
			st_q.common_clk     <= CTRL_BIT_RST;
			st_q.ext_synch      <= CTRL_BIT_RST;
			st_q.clk_pm_en      <= CTRL_BIT_RST;
			st_q.auto_width_dis <= CTRL_BIT_RST;
			st_q.port_num       <= PORT_NUM_RST;
			st_q.strap_done     <= 1'b0;
			st_q.extra_os       <= 1'b0;
			st_q.width_grant    <= 1'b0;
			st_q.clkreq_lvl     <= 1'b0;
			st_q.clk_st         <= CLK_HELD;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from state
	assign av_readdata              = st_q.rdata;
	assign av_waitrequest           = st_q.wait_req;
	assign aspm_control_level       = st_q.aspm_ctrl;
	assign common_clock_config      = st_q.common_clk;
	assign extended_synch           = st_q.ext_synch;
	assign completion_boundary      = st_q.compl_bnd;
	assign autonomous_width_disable = st_q.auto_width_dis;
	assign tx_extra_ordered_sets    = st_q.extra_os;
	assign width_change_grant       = st_q.width_grant;
	assign clkreq_out               = st_q.clkreq_lvl;
	assign clkreq_oe_n              = (st_q.clk_st == CLK_RELEASED);

endmodule : pcie_link_cap_ctrl_regs

`default_nettype wire

//--- bench/link_regs_checker_assertions.sv
/* Checker on the register bank ports.
   Assumes it is bound into the bank. */
`timescale 1ns/1ps
`default_nettype none
module link_regs_checker
	import pcie_link_regs_pkg::*;
(
	// Clock, reset, bus
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire av_req_t     av_req,
	input wire logic [31:0] av_readdata,
	input wire logic        av_waitrequest,
	// Link side
	input wire link_stat_t  link_stat,
	input wire logic [1:0]  aspm_control_level,
	input wire logic        common_clock_config,
	input wire logic        extended_synch,
	input wire logic        autonomous_width_disable,
	input wire logic        tx_extra_ordered_sets,
	input wire logic        width_change_grant,
	input wire logic        clkreq_oe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Request taken at this edge
	wire tk = (av_req.read | av_req.write) & av_waitrequest;
	bus_answer_a: assert property (tk |=> !av_waitrequest ##1 av_waitrequest)
		else $error("bus answer not one cycle");
	cap_zero_a: assert property (tk && av_req.read && av_req.address == LINK_CAP_OFFSET
		|=> av_readdata[21:19] == 3'h0 && !av_readdata[23]) else $error("endpoint cap bits set");
	ctrl_rsvd_a: assert property (tk && av_req.read && av_req.address == LINK_CTRL_OFFSET
		|=> av_readdata[31:10] == 22'h00_0000 && av_readdata[5:4] == 2'h0 && !av_readdata[2])
		else $error("reserved control bits set");
	ccc_write_a: assert property (tk && av_req.write && av_req.address == LINK_CTRL_OFFSET
		&& av_req.byteenable[0] |=> common_clock_config == $past(av_req.writedata[6]))
		else $error("common clock bit not written");
	aspm_reset_a: assert property ($rose(rstn) |-> aspm_control_level == 2'h0 && !extended_synch)
		else $error("control not reset");
	tx_extra_a: assert property (extended_synch && (link_stat.l0s_exiting || link_stat.in_recovery)
		|=> tx_extra_ordered_sets) else $error("no extra ordered sets");
	width_block_a: assert property (link_stat.width_change_req && autonomous_width_disable
		&& !link_stat.width_reduce_fix |=> !width_change_grant) else $error("width change not blocked");
	clkreq_rise_a: assert property ($rose(clkreq_oe_n) |-> $past(link_stat.link_low_power)
		&& !$past(link_stat.clk_wake)) else $error("clock request released early");
endmodule : link_regs_checker
bind pcie_link_cap_ctrl_regs link_regs_checker chk (.clk_sys, .rstn, .av_req, .av_readdata,
	.av_waitrequest, .link_stat, .aspm_control_level, .common_clock_config, .extended_synch,
	.autonomous_width_disable, .tx_extra_ordered_sets, .width_change_grant, .clkreq_oe_n);
`default_nettype wire

//--- bench/link_partner_model.sv
/* Link layer partner: status bits and the CLKREQ# wire.
   Assumes the bench gives the wanted status. */
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
	import pcie_link_regs_pkg::*;
(
	// Clock and wanted status
	input  wire logic       clk_sys,
	input  wire logic [5:0] want,
	// Pin parts and wire levels
	input  wire logic       clkreq_out,
	input  wire logic       clkreq_oe_n,
	output var link_stat_t  link_stat,
	output logic            clkreq_pin,
	output logic            refclk_on
);
	// Status moves just after an edge
	always_ff @(posedge clk_sys) link_stat <= link_stat_t'(want);
	// Pull-up wins once the pin is released
	assign clkreq_pin = clkreq_oe_n ? 1'b1 : clkreq_out;
	// Clock stopped only while released in low power
	assign refclk_on = !(clkreq_pin && link_stat.link_low_power);
endmodule : link_partner_model
`default_nettype wire

//--- bench/tb_pcie_link_cap_ctrl_regs.sv
/* Bench for the link register bank: access table, then link cases.
   Assumes the bank's default parameters. */
`timescale 1ns/1ps
`default_nettype none
module tb_pcie_link_cap_ctrl_regs
	import pcie_link_regs_pkg::*;
	;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} row_t;
	localparam logic [31:0] CAP = {8'h5A, 2'h1, 3'h0, 1'b1, 3'h2, 3'h1, 2'h3, 6'h04, 4'h1};
	logic clk_sys, rstn, av_waitrequest, common_clock_config, extended_synch, completion_boundary;
	logic autonomous_width_disable, tx_extra_ordered_sets, width_change_grant, clkreq_out, clkreq_oe_n;
	logic pin, ref_on;
	logic [1:0]  aspm_control_level;
	logic [5:0]  lk;
	logic [31:0] av_readdata, rd, ctl;
	av_req_t     req;
	link_stat_t  link_stat;
	int failures = 0, checks = 0, cyc = 0;
	// Write, read back, expected word; upper lanes ignored
	row_t rows [8] = '{'{LINK_CAP_OFFSET, 32'hFFFF_FFFF, 4'hF, CAP},
		'{LINK_CTRL_OFFSET, 32'hFFFF_FFFF, 4'hF, 32'h0000_03CB}, '{LINK_CTRL_OFFSET, 32'h0, 4'h3, 32'h0},
		'{LINK_CTRL_OFFSET, 32'hFFFF_FFFF, 4'h1, 32'h0000_00CB},
		'{LINK_CTRL_OFFSET, 32'hFFFF_FFFF, 4'h2, 32'h0000_03CB},
		'{LINK_CTRL_OFFSET, 32'h0, 4'h1, 32'h0000_0300}, '{8'h14, 32'hFFFF_FFFF, 4'hF, 32'h0},
		'{LINK_CTRL_OFFSET, 32'h0000_0042, 4'hF, 32'h0000_0042}};
	pcie_link_cap_ctrl_regs DUT (.clk_sys, .rstn, .av_req(req), .av_readdata, .av_waitrequest,
		.port_number_strap(8'h5A), .link_stat, .aspm_control_level, .common_clock_config,
		.extended_synch, .completion_boundary, .autonomous_width_disable, .tx_extra_ordered_sets,
		.width_change_grant, .clkreq_out, .clkreq_oe_n);
	link_partner_model partner (.clk_sys, .want(lk), .clkreq_out, .clkreq_oe_n, .link_stat,
		.clkreq_pin(pin), .refclk_on(ref_on));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Hold the request until waitrequest is seen low
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
		do @(posedge clk_sys); while (av_waitrequest !== 1'b0);
		rd = av_readdata;
		req <= '0;
		@(posedge clk_sys);
	endtask : acc
	// Partner then bank each take one edge
	task automatic link(input logic [5:0] v);
		lk <= v;
		repeat (3) @(posedge clk_sys);
	endtask : link
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Run takes under a hundred cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		rstn = 1'b0;
		req = '0;
		lk = '0;
		ctl = '0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		foreach (rows[i]) begin
			acc(1'b1, rows[i].a, rows[i].d, rows[i].be);
			acc(1'b0, rows[i].a, 32'h0, 4'hF);
			chk("readback", rows[i].e, rd);
			if (rows[i].a == LINK_CTRL_OFFSET) ctl = rows[i].e;
			chk("ctl_out", 32'({ctl[9], ctl[7:6], ctl[3], ctl[1:0]}), 32'({autonomous_width_disable,
				extended_synch, common_clock_config, completion_boundary, aspm_control_level}));
		end
		$display("test table done");
		acc(1'b1, LINK_CTRL_OFFSET, 32'h0, 4'h3);
		link(6'b10_0000);
		chk("pin_held", 32'h0, 32'(pin));
		chk("refclk", 32'h1, 32'(ref_on));
		acc(1'b1, LINK_CTRL_OFFSET, 32'h0000_0100, 4'h3);
		link(6'b10_0000);
		chk("pin_free", 32'h1, 32'(pin));
		chk("refclk_off", 32'h0, 32'(ref_on));
		link(6'b11_0000);
		chk("pin_wake", 32'h0, 32'(pin));
		acc(1'b1, LINK_CTRL_OFFSET, 32'h0000_0280, 4'h3);
		link(6'b00_1000);
		chk("tx_l0s", 32'h1, 32'(tx_extra_ordered_sets));
		link(6'b00_0111);
		chk("tx_recov", 32'h1, 32'(tx_extra_ordered_sets));
		chk("grant_fix", 32'h1, 32'(width_change_grant));
		link(6'b00_0010);
		chk("grant_off", 32'h0, 32'(width_change_grant));
		acc(1'b1, LINK_CTRL_OFFSET, 32'hFFFF_FFFF, 4'h3);
		rstn <= 1'b0;
		@(posedge clk_sys);
		chk("rst_out", 32'h1, 32'({aspm_control_level, extended_synch, clkreq_oe_n, av_waitrequest}));
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("grant_on", 32'h1, 32'(width_change_grant));
		acc(1'b0, LINK_CTRL_OFFSET, 32'h0, 4'hF);
		chk("ctl_rst", 32'h0, rd);
		$display("test link done");
		end_of_test();
	end
endmodule : tb_pcie_link_cap_ctrl_regs
`default_nettype wire
